// File: rtl/core_fetch_pipeline_pc_stack.sv
// Instruction sequencer: phases, prefetch, PC, return stack, ALU
`timescale 1ns/10ps
module core_fetch_pipeline_pc_stack (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [core_seq_pkg::PC_W-1:0] prog_addr,
    input wire logic [15:0] prog_rdata,
    input wire logic irq_req,
    output logic int_ack,
    output core_seq_pkg::phase_t cycle_phases
);
    import core_seq_pkg::*;

    logic [1:0] ctrl;
    logic [7:0] div_cnt;
    logic [PC_W-1:0] pc;
    logic [15:0] ir;
    logic ir_valid;
    logic hold;
    logic [7:0] acc;
    logic [7:0] mp;
    flags_t flags;
    logic [7:0] dmem [0:DM_DEPTH-1];
    logic [PC_W-1:0] stk [0:5];
    logic [2:0] wp;
    logic [2:0] count;
    logic pc_low_pend;
    logic [7:0] pc_low_val;
    alu_out_t alu;

    // Oscillator select and phase tick
    wire slow_sel = ctrl[CTRL_SLOW];
    wire div_end = div_cnt == SLOW_DIV - 8'h01;
    wire tick = ctrl[CTRL_RUN] & (!slow_sel | div_end);
    wire [7:0] next_div = (slow_sel & !div_end) ? div_cnt + 8'h01 : 8'h00;
    wire t1 = tick & (cycle_phases == PH1);
    wire t4 = tick & (cycle_phases == PH4);

    // Divider for the slow oscillator
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            div_cnt <= 8'h00;
        end else begin
            div_cnt <= next_div;
        end
    end

    // Four-phase sequencer
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cycle_phases <= PH1;
        end else if (tick) begin
            cycle_phases <= phase_t'(cycle_phases + 2'h1);
        end
    end

    // Instruction decode
    wire is_br = ir[IW_BRANCH];
    wire is_call = is_br & ir[IW_CALL];
    wire op_t op = op_t'(ir[14:10]);
    wire dest_mem = ir[IW_DEST];
    wire exec = t4 & ir_valid & !hold;
    wire is_sret = !is_br & (op == OP_SUBR_RETURN);
    wire is_iret = !is_br & (op == OP_INT_RETURN);

    // Operand address with indirect access through the pointer
    wire [5:0] ea = (ir[5:0] == DM_IND) ? mp[5:0] : ir[5:0];
    wire [7:0] mval = (ea == DM_ACC) ? acc :
                      (ea == DM_PC_LOW) ? pc[7:0] :
                      (ea == DM_STATUS) ? {4'h0, flags} :
                      (ea == DM_MP) ? mp : dmem[ea];

    // Shared adder for add, subtract and their carry forms
    wire is_sub = (op == OP_SUB) | (op == OP_SBC);
    wire [7:0] addend = is_sub ? ~mval : mval;
    wire cin = (op == OP_ADD) ? 1'b0 : (op == OP_SUB) ? 1'b1 : flags.c;
    wire [8:0] sum9 = {1'b0, acc} + {1'b0, addend} + {8'h00, cin};
    wire [4:0] sum5 = {1'b0, acc[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
    wire add_ov = (acc[7] == addend[7]) & (sum9[7] != acc[7]);

    // Decimal adjust of the accumulator
    wire daa_lo = (acc[3:0] > 4'h9) | flags.ac;
    wire [8:0] daa1 = {1'b0, acc} + (daa_lo ? 9'h006 : 9'h000);
    wire daa_hi = (daa1[7:4] > 4'h9) | flags.c | daa1[8];
    wire [7:0] daa_res = daa1[7:0] + (daa_hi ? 8'h60 : 8'h00);

    // Eight-bit ALU result, flags, destination and skip decision
    always_comb begin
        logic zupd;
        zupd = 1'b0;
        alu.res = 8'h00;
        alu.f = flags;
        alu.to_acc = 1'b0;
        alu.to_mem = 1'b0;
        alu.skip = 1'b0;
        unique case (op)
            OP_NOP, OP_SUBR_RETURN, OP_INT_RETURN: begin
            end
            OP_MOVA: begin
                alu.res = mval;
                alu.to_acc = 1'b1;
            end
            OP_MOVM: begin
                alu.res = acc;
                alu.to_mem = 1'b1;
            end
            OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin
                alu.res = sum9[7:0];
                alu.f.c = sum9[8];
                alu.f.ac = sum5[4];
                alu.f.ov = add_ov;
                zupd = 1'b1;
            end
            OP_DEC_ADJ: begin
                alu.res = daa_res;
                alu.f.c = daa_hi;
            end
            OP_AND, OP_OR, OP_XOR, OP_CPL: begin
                alu.res = (op == OP_AND) ? (acc & mval) :
                          (op == OP_OR) ? (acc | mval) :
                          (op == OP_XOR) ? (acc ^ mval) : ~mval;
                zupd = 1'b1;
            end
            OP_RR: alu.res = {mval[0], mval[7:1]};
            OP_RL: alu.res = {mval[6:0], mval[7]};
            OP_RRC: begin
                alu.res = {flags.c, mval[7:1]};
                alu.f.c = mval[0];
            end
            OP_RLC: begin
                alu.res = {mval[6:0], flags.c};
                alu.f.c = mval[7];
            end
            OP_INC, OP_DEC: begin
                alu.res = (op == OP_INC) ? mval + 8'h01 : mval - 8'h01;
                zupd = 1'b1;
            end
            OP_SZ: alu.skip = mval == 8'h00;
            OP_SNZ: alu.skip = mval != 8'h00;
            OP_SIZ, OP_SDZ: begin
                alu.res = (op == OP_SIZ) ? mval + 8'h01 : mval - 8'h01;
                alu.skip = alu.res == 8'h00;
            end
            default: begin
            end
        endcase
        if (zupd) begin
            alu.f.z = alu.res == 8'h00;
        end
        if (op inside {[OP_ADD:OP_DEC], OP_SIZ, OP_SDZ}) begin
            alu.to_acc = !dest_mem;
            alu.to_mem = dest_mem;
        end
    end

    // Write strobes into accumulator and data memory space
    wire alu_exec = exec & !is_br;
    wire mem_we = alu_exec & alu.to_mem;
    wire acc_we = alu_exec & (alu.to_acc | (mem_we & (ea == DM_ACC)));
    wire mem_pc_wr = mem_we & (ea == DM_PC_LOW);
    wire stat_we = mem_we & (ea == DM_STATUS);

    // Program flow changes at the end of the execute phases
    wire stack_full = count == STACK_DEPTH;
    wire [2:0] rp = (wp == 3'h0) ? STACK_LAST : wp - 3'h1;
    wire [2:0] wp_inc = (wp == STACK_LAST) ? 3'h0 : wp + 3'h1;
    wire pop = exec & (is_sret | is_iret);
    wire skip_taken = alu_exec & alu.skip;
    wire exec_flow = exec & (is_br | is_sret | is_iret | skip_taken | mem_pc_wr);
    wire pc_low_apply = t4 & pc_low_pend & !hold & !exec_flow;
    wire int_take = t4 & irq_req & !stack_full & !hold & !exec_flow & !pc_low_pend;
    wire push = (exec & is_call) | int_take;
    wire flow = exec_flow | pc_low_apply | int_take;
    wire ext_start = alu_exec & ir[IW_EXT] & !exec_flow;
    wire [PC_W-1:0] flow_target = int_take ? INT_VECTOR :
                                  pc_low_apply ? {pc[11:8], pc_low_val} :
                                  is_br ? ir[PC_W-1:0] :
                                  pop ? stk[rp] :
                                  mem_pc_wr ? {pc[11:8], alu.res} : pc;
    assign int_ack = int_take;

    // Program counter and fetch address
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pc <= PC_RESET;
            prog_addr <= PC_RESET;
        end else if (t4 & flow) begin
            pc <= flow_target;
        end else if (t1 & !hold) begin
            prog_addr <= pc;
            pc <= pc + 12'h001;
        end
    end

    // Prefetched word and its validity; a flow change makes it a dummy
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ir <= 16'h0000;
            ir_valid <= 1'b0;
        end else if (t4 & !hold) begin
            ir <= prog_rdata;
            ir_valid <= !flow;
        end
    end

    // Second cycle of an extended instruction
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            hold <= 1'b0;
        end else if (t4) begin
            hold <= ext_start;
        end
    end

    // Stack pointer and depth; the pointer is hidden, the depth and full flag read back in the status register
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wp <= SP_RESET;
            count <= SP_RESET;
        end else if (push) begin
            wp <= wp_inc;
            count <= stack_full ? count : count + 3'h1;
        end else if (pop) begin
            wp <= rp;
            count <= (count == 3'h0) ? count : count - 3'h1;
        end
    end

    // Stack storage; the address of the discarded prefetch is the return point
    always_ff @(posedge clk_sys) begin
        if (push) begin
            stk[wp] <= prog_addr;
        end
    end

    // Accumulator, pointer and status flags
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            acc <= 8'h00;
            mp <= 8'h00;
            flags <= '0;
        end else begin
            if (acc_we) acc <= alu.res;
            if (mem_we & (ea == DM_MP)) mp <= alu.res;
            if (alu_exec) flags <= stat_we ? flags_t'(alu.res[3:0]) : alu.f;
        end
    end

    // General purpose data memory
    always_ff @(posedge clk_sys) begin
        if (mem_we & (ea >= DM_GEN_BASE)) begin
            dmem[ea] <= alu.res;
        end
    end

    // APB decode
    wire apb_setup = psel & !penable;
    wire apb_acc = psel & penable;
    wire hit = (paddr == ADDR_CTRL) | (paddr == ADDR_PC_LOW) |
               (paddr == ADDR_STATUS) | (paddr == ADDR_ACC);
    wire apb_wr = apb_acc & pwrite & hit;
    wire pc_low_wr = apb_wr & (paddr == ADDR_PC_LOW);
    wire [31:0] rd_word = (paddr == ADDR_CTRL) ? {30'h0, ctrl} :
                          (paddr == ADDR_PC_LOW) ? {24'h0, pc[7:0]} :
                          (paddr == ADDR_STATUS) ? {12'h000, stack_full, count, flags, pc} :
                          (paddr == ADDR_ACC) ? {24'h0, acc} : 32'h0;
    assign pready = 1'b1;
    assign pslverr = apb_acc & !hit;

    // Control register and registered read data
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ctrl <= CTRL_RESET;
            prdata <= 32'h0;
        end else begin
            if (apb_wr & (paddr == ADDR_CTRL)) ctrl <= pwdata[1:0];
            if (apb_setup) prdata <= rd_word;
        end
    end

    // Pending software write of the PC low byte; a new write wins over apply
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pc_low_pend <= 1'b0;
            pc_low_val <= 8'h00;
        end else if (pc_low_wr) begin
            pc_low_pend <= 1'b1;
            pc_low_val <= pwdata[7:0];
        end else if (pc_low_apply) begin
            pc_low_pend <= 1'b0;
        end
    end

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_phase_wrap: assert property (t4 |=> cycle_phases == PH1) else $error("phase not wrapped");
    a_pc_step: assert property (t1 & !hold |=> pc == $past(pc) + 12'h001) else $error("pc not incremented");
    a_fetch_addr: assert property (t1 & !hold |=> prog_addr == $past(pc)) else $error("fetch address wrong");
    a_flow_dummy: assert property (t4 & flow |=> !ir_valid) else $error("no dummy after flow");
    a_page_jump: assert property (pc_low_apply |=> pc == {$past(pc[11:8]), $past(pc_low_val)})
        else $error("page jump wrong");
    a_stack_push: assert property (push & !stack_full |=> count == $past(count) + 3'h1)
        else $error("push depth wrong");
    a_stack_pop: assert property (pop & count != 3'h0 |=> count == $past(count) - 3'h1)
        else $error("pop depth wrong");
    a_irq_withheld: assert property (stack_full |-> !int_ack) else $error("ack while full");
    a_call_overflow: assert property (push & stack_full |=> stack_full && wp == $past(wp_inc))
        else $error("overflow wrong");
    a_dummy_quiet: assert property (t4 & !ir_valid & !int_take |=> acc == $past(acc) && flags == $past(flags))
        else $error("dummy changed state");
    a_ext_two: assert property (ext_start |=> hold) else $error("extended op not held");
    a_ext_stay: assert property (hold & !t4 |=> hold) else $error("extended hold dropped early");

    c_call: cover property (exec & is_call);
    c_skip: cover property (skip_taken);
    c_int: cover property (int_take);
    c_overflow: cover property (push & stack_full);
    c_ext: cover property (ext_start);
endmodule

// File: rtl/core_seq_pkg.sv
// Constants, types and field layouts of the instruction sequencer core
// Overview of operation
// - Clock from fast or slow internal oscillator
// - Four phases make one instruction cycle
// - Phase one advances PC and fetches
// - Phases two to four decode and execute
// - Standard ops one cycle, extended ops two
// - PC-changing instructions take one extra cycle
// - PC increments by one word otherwise
// - Jump, call, interrupt, reset load target
// - Taken skip discards prefetch, inserts dummy cycle
// - Only PC low byte is software writable; status register reads all 12 PC bits
// - PC low write jumps within page
// - Six-entry hidden stack of PC values
// - Call or interrupt pushes return address
// - Return instructions pop stack into PC
// - Reset empties stack pointer
// - Full stack withholds interrupt acknowledge
// - Call on full stack overwrites oldest
// - Eight-bit ALU works through accumulator
// - ALU writes destination and updates flags
// - ALU supports arithmetic, logic, rotate forms
// - Special registers in data memory, direct/indirect
package core_seq_pkg;
    localparam int PC_W = 12;
    localparam logic [PC_W-1:0] PC_RESET = 12'h000;
    localparam logic [PC_W-1:0] INT_VECTOR = 12'h004;
    localparam int DM_DEPTH = 64;
    localparam logic [2:0] STACK_DEPTH = 3'h6;
    localparam logic [2:0] STACK_LAST = 3'h5;
    localparam logic [2:0] SP_RESET = 3'h0;
    localparam logic [7:0] SLOW_DIV = 8'h20;
    // Data memory special register addresses
    localparam logic [5:0] DM_IND = 6'h00;
    localparam logic [5:0] DM_MP = 6'h01;
    localparam logic [5:0] DM_ACC = 6'h02;
    localparam logic [5:0] DM_PC_LOW = 6'h03;
    localparam logic [5:0] DM_STATUS = 6'h04;
    localparam logic [5:0] DM_GEN_BASE = 6'h05;
    // Instruction word fields
    localparam int IW_BRANCH = 15;
    localparam int IW_CALL = 14;
    localparam int IW_DEST = 9;
    localparam int IW_EXT = 8;
    // APB register offsets and reset values
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PC_LOW = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_ACC = 8'h0c;
    localparam int CTRL_RUN = 0;
    localparam int CTRL_SLOW = 1;
    localparam logic [1:0] CTRL_RESET = 2'h1;

    typedef enum logic [1:0] {PH1, PH2, PH3, PH4} phase_t;

    typedef enum logic [4:0] {
        OP_NOP, OP_MOVA, OP_MOVM, OP_ADD, OP_ADC, OP_SUB, OP_SBC,
        OP_DEC_ADJ, OP_AND, OP_OR, OP_XOR, OP_CPL, OP_RR, OP_RRC,
        OP_RL, OP_RLC, OP_INC, OP_DEC, OP_SZ, OP_SNZ, OP_SIZ, OP_SDZ,
        OP_SUBR_RETURN, OP_INT_RETURN
    } op_t;

    typedef struct packed {
        logic ov;
        logic z;
        logic ac;
        logic c;
    } flags_t;

    typedef struct packed {
        logic [7:0] res;
        flags_t f;
        logic to_acc;
        logic to_mem;
        logic skip;
    } alu_out_t;
endpackage

// File: tb/prog_irq_model.sv
// Program memory and interrupt request model facing the sequencer core
`timescale 1ns/10ps
module prog_irq_model (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic slow,
    input wire logic irq_set,
    input wire logic [core_seq_pkg::PC_W-1:0] prog_addr,
    input wire logic int_ack,
    output logic [15:0] prog_rdata,
    output logic irq_req
);
    import core_seq_pkg::*;
    logic [15:0] mem [0:(1<<PC_W)-1];
    logic [PC_W-1:0] addr_d1;
    logic [PC_W-1:0] addr_d2;
    wire logic settled = !slow || (addr_d2 == prog_addr);
    // Slow memory shows the inverted word until two cycles have passed
    assign prog_rdata = settled ? mem[prog_addr] : ~mem[prog_addr];
    // Address pipeline of the slow memory
    always_ff @(posedge clk_sys) begin
        addr_d1 <= prog_addr;
        addr_d2 <= addr_d1;
    end
    // Request flag stays set until the core acknowledges it
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            irq_req <= 1'b0;
        end else if (irq_set) begin
            irq_req <= 1'b1;
        end else if (int_ack) begin
            irq_req <= 1'b0;
        end
    end
endmodule

// File: tb/tb_core_fetch_pipeline_pc_stack.sv
// Self-checking bench for the instruction sequencer core
`timescale 1ns/10ps
module tb_core_fetch_pipeline_pc_stack;
    import core_seq_pkg::*;
    typedef struct {logic [32:0] v; logic [32:0] m;} note_t;
    logic clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, slow, irq_set, irq_req, int_ack;
    logic [7:0] paddr;
    logic [7:0] ua;
    logic [31:0] pwdata, prdata;
    logic [31:0] seed = 32'h0000005a;
    logic [PC_W-1:0] prog_addr;
    logic [15:0] prog_rdata;
    phase_t cycle_phases;
    int mismatches = 0;
    int check_count = 0;
    int acks = 0;
    note_t rd_q[$];
    logic [PC_W-1:0] fetch_q[$];

    core_fetch_pipeline_pc_stack uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .prog_addr(prog_addr), .prog_rdata(prog_rdata), .irq_req(irq_req), .int_ack(int_ack),
        .cycle_phases(cycle_phases));
    prog_irq_model model (.clk_sys(clk_sys), .sys_rst(sys_rst), .slow(slow), .irq_set(irq_set),
        .prog_addr(prog_addr), .int_ack(int_ack), .prog_rdata(prog_rdata), .irq_req(irq_req));

    // Clock at 100 MHz
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task compare_read(input logic [32:0] got, input note_t n);
        check_count++;
        if ((got & n.m) !== (n.v & n.m)) begin
            mismatches++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got & n.m, n.v & n.m);
        end
    endtask

    task compare_fetch(input logic [PC_W-1:0] got, input logic [PC_W-1:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer: setup, then access until pready is sampled high
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
        rd_q.push_back('{e, m});
        apb(1'b0, a, 32'h0);
    endtask

    task wait_for(input phase_t ph, input logic [PC_W-1:0] a);
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (!(cycle_phases === ph && prog_addr === a) && n < 2000);
    endtask

    task close_out;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Watcher: read answers at the access edge, fetch addresses once each cycle
    always @(posedge clk_sys) begin
        if (psel && penable && pready && !pwrite && rd_q.size() > 0) begin
            compare_read({pslverr, prdata}, rd_q.pop_front());
        end
        if (int_ack === 1'b1) acks++;
        #1;
        if (sys_rst === 1'b0 && cycle_phases === PH2 && fetch_q.size() > 0) begin
            compare_fetch(prog_addr, fetch_q.pop_front());
        end
    end

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        close_out;
    end

    // Main sequence
    initial begin
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        irq_set = 1'b0;
        seed = xorshift(seed);
        slow = seed[0];
        for (int i = 0; i < (1 << PC_W); i++) model.mem[i] = 16'h0000;
        model.mem[12'h000] = 16'h8040;
        model.mem[12'h041] = 16'hc100;
        model.mem[12'h100] = 16'h5800;
        model.mem[INT_VECTOR] = 16'h5c00;
        // Extended no-op, complement of status into accumulator, accumulator doubled
        model.mem[12'h043] = 16'h0100;
        model.mem[12'h044] = 16'h2c04;
        model.mem[12'h045] = 16'h0c02;
        // Call into a self-calling loop that fills and overflows the stack
        model.mem[12'h083] = 16'hc0a0;
        model.mem[12'h0a0] = 16'hc0a0;
        model.mem[12'h0a1] = 16'h80a1;
        model.mem[12'h0b0] = 16'h5800;
        fetch_q = '{12'h000, 12'h001, 12'h040, 12'h041, 12'h042, 12'h100, 12'h101};
        for (int a = 'h42; a <= 'h50; a++) begin
            fetch_q.push_back(a[PC_W-1:0]);
            if (a == 'h44) fetch_q.push_back(a[PC_W-1:0]);
        end
        fetch_q.push_back(INT_VECTOR);
        fetch_q.push_back(INT_VECTOR + 12'h001);
        for (int a = 'h50; a <= 'h61; a++) fetch_q.push_back(a[PC_W-1:0]);
        for (int a = 'h80; a <= 'h82; a++) fetch_q.push_back(a[PC_W-1:0]);
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd(ADDR_CTRL, {1'b0, 30'h0, CTRL_RESET}, 33'h1_ffff_ffff);
        rd(ADDR_STATUS, 33'h0, 33'h1_000f_0000);
        rd(ADDR_PC_LOW, 33'h0, 33'h1_ffff_ff00);
        seed = xorshift(seed);
        ua = {seed[7:2], 2'b00} | 8'h10;
        apb(1'b1, ua, seed);
        rd(ua, 33'h1_0000_0000, 33'h1_ffff_ffff);
        wait_for(PH2, 12'h050);
        @(posedge clk_sys);
        irq_set <= 1'b1;
        @(posedge clk_sys);
        irq_set <= 1'b0;
        wait_for(PH4, 12'h060);
        apb(1'b1, ADDR_PC_LOW, 32'h00000080);
        for (int n = 0; n < 200 && fetch_q.size() > 0; n++) @(posedge clk_sys);
        compare_fetch(fetch_q.size(), 12'h000);
        compare_read({1'b0, acks[31:0]}, '{33'h1, 33'h1_ffff_ffff});
        rd(ADDR_STATUS, 33'h0, 33'h1_000f_0000);
        rd(ADDR_ACC, 33'h0_0000_00fe, 33'h1_ffff_ffff);
        // Stack fills and overflows; a request must then be withheld
        repeat (80) @(posedge clk_sys);
        irq_set <= 1'b1;
        @(posedge clk_sys);
        irq_set <= 1'b0;
        repeat (40) @(posedge clk_sys);
        rd(ADDR_STATUS, 33'h0_000e_3000, 33'h1_000f_f000);
        compare_read({1'b0, acks[31:0]}, '{33'h1, 33'h1_ffff_ffff});
        // Page jump to a return frees an entry and lets the request through
        apb(1'b1, ADDR_PC_LOW, 32'h000000b0);
        repeat (100) @(posedge clk_sys);
        rd(ADDR_STATUS, 33'h0_0005_3000, 33'h1_000f_f000);
        compare_read({1'b0, acks[31:0]}, '{33'h2, 33'h1_ffff_ffff});
        // Slow oscillator select reads back
        apb(1'b1, ADDR_CTRL, 32'h00000003);
        rd(ADDR_CTRL, 33'h0_0000_0003, 33'h1_ffff_ffff);
        repeat (3) @(posedge clk_sys);
        close_out;
    end
endmodule
